/* File: src/ldd_top.sv */
// Instruction decoder and display-RAM access for a bit-map LCD driver.
// Assumes an 80-style host bus on pins (strobes asynchronous to sys_clk_in).
`timescale 1ns/1ps
// Behaviour
// - Display on/off command low bit: one shows panel, zero blanks it.
// - Display off together with static drive on enters power save.
// - Start-line command loads five-bit line address from low bits.
// - Start line drives first common; following lines up to duty count.
// - Page command loads two-bit page used for host RAM accesses.
// - Page changes never alter what the panel shows.
// - Command with top bit zero loads seven-bit column address, except in RMW where it is ignored.
// - Column advances per RAM access except reads in RMW, stops at 50H, page unchanged.
// - Status read: busy, direction, off, init in bits 7..4, zeros below.
// - Busy is one while operating or initialising; host waits for zero.
// - Direction flag one for normal mapping, zero for mirrored 79-n.
// - Off flag reads one when display is off.
// - Init flag reads one during reset-pin or reset-command initialisation.
// - Data write stores the byte at page and column, column advances.
// - Data read returns the byte latched by the previous read, then latches page and column, advances unless RMW.
// - Direction command low bit: zero mirrored, one normal.
// - Static drive on with display on forces all commons active and lights the panel.
// - Duty command low bit: zero one-sixteenth, one one-thirty-second.
// - Bus cycles classified by select and strobes into four kinds.
// - RMW: writes advance, reads do not; end restores entry column.
// - Display-on or static-off commands leave power save.
// - Reset command sets start line zero and page 3, RAM untouched.
module ldd_top
  import ldd_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic        sys_clk_in,                // 25 MHz system clock
  input  wire logic        resetn_in,                 // Async reset, active low
  input  wire logic        cs_n_in,                   // Chip select, active low
  input  wire logic        data_command_select_in,    // 1 data, 0 command/status
  input  wire logic        rd_n_in,                   // Read strobe, active low
  input  wire logic        wr_n_in,                   // Write strobe, active low
  input  wire logic [7:0]  d_in,                      // Data bus input
  output logic      [7:0]  d_out,                     // Data bus output
  output logic             d_oe_out,                  // Data bus drive enable
  output logic      [31:0] common_out,                // Common drives, bit 0 first common
  output logic      [79:0] seg_out,                   // Segment drives
  output logic             power_save_out,            // Power-save mode
  output logic             busy_out                   // Busy state
);
  initial begin
    if (FIFO_DEPTH < 2) $error("FIFO_DEPTH too small");
  end

  // Host pin synchronisers and edge history
  logic [1:0] cs_s_q, dcs_s_q, rd_s_q, wr_s_q;
  logic [7:0] d_s1_q, d_s2_q;
  logic       rd_d3_q, wr_d3_q;
  logic       rd_start, rd_end, wr_end;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cs_s_q  <= 2'h3;
      dcs_s_q <= 2'h0;
      rd_s_q  <= 2'h3;
      wr_s_q  <= 2'h3;
      d_s1_q  <= 8'h00;
      d_s2_q  <= 8'h00;
      rd_d3_q <= 1'b1;
      wr_d3_q <= 1'b1;
    end else begin
      cs_s_q  <= {cs_s_q[0], cs_n_in};
      dcs_s_q <= {dcs_s_q[0], data_command_select_in};
      rd_s_q  <= {rd_s_q[0], rd_n_in};
      wr_s_q  <= {wr_s_q[0], wr_n_in};
      d_s1_q  <= d_in;
      d_s2_q  <= d_s1_q;
      rd_d3_q <= rd_s_q[1];
      wr_d3_q <= wr_s_q[1];
    end
  end

  // Cycle classification from select and strobes
  assign rd_start = !cs_s_q[1] && !rd_s_q[1] && rd_d3_q;
  assign rd_end   = !cs_s_q[1] && rd_s_q[1] && !rd_d3_q;
  assign wr_end   = !cs_s_q[1] && wr_s_q[1] && !wr_d3_q;

  logic data_wr, cmd_wr, data_rd_end;
  assign data_wr     = wr_end && dcs_s_q[1];
  assign cmd_wr      = wr_end && !dcs_s_q[1];
  assign data_rd_end = rd_end && dcs_s_q[1];

  // Command decode
  logic c_onoff, c_adc, c_static, c_duty, c_start, c_page, c_col, c_rmw, c_end, c_rst;
  assign c_onoff  = cmd_wr && op_match(d_s2_q, OP_ON_OFF, MASK_BIT);
  assign c_adc    = cmd_wr && op_match(d_s2_q, OP_ADC, MASK_BIT);
  assign c_static = cmd_wr && op_match(d_s2_q, OP_STATIC, MASK_BIT);
  assign c_duty   = cmd_wr && op_match(d_s2_q, OP_DUTY, MASK_BIT);
  assign c_start  = cmd_wr && op_match(d_s2_q, OP_START, MASK_START);
  assign c_page   = cmd_wr && op_match(d_s2_q, OP_PAGE, MASK_PAGE);
  assign c_col    = cmd_wr && op_match(d_s2_q, OP_COL, MASK_COL);
  assign c_rmw    = cmd_wr && op_match(d_s2_q, OP_RMW, MASK_FULL);
  assign c_end    = cmd_wr && op_match(d_s2_q, OP_END, MASK_FULL);
  assign c_rst    = cmd_wr && op_match(d_s2_q, OP_RESET, MASK_FULL);

  // Mode registers
  logic disp_on_q, static_q, duty32_q, dir_q, rmw_q, ps_q;
  logic disp_on_d, static_d;
  assign disp_on_d = c_onoff ? d_s2_q[0] : disp_on_q;
  assign static_d  = c_static ? d_s2_q[0] : static_q;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      disp_on_q <= 1'b0;
      static_q  <= 1'b0;
      duty32_q  <= RST_DUTY32;
      dir_q     <= RST_DIR;
      ps_q      <= 1'b0;
    end else begin
      disp_on_q <= disp_on_d;
      static_q  <= static_d;
      ps_q      <= !disp_on_d && static_d;
      if (c_adc) begin
        dir_q <= d_s2_q[0];
      end
      if (c_duty) begin
        duty32_q <= d_s2_q[0];
      end
    end
  end

  // Start line and page registers
  logic [4:0] start_q;
  logic [1:0] page_q;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_q <= RST_START;
      page_q  <= RST_PAGE;
    end else if (c_rst) begin
      start_q <= RST_START;
      page_q  <= RST_PAGE;
    end else begin
      if (c_start) begin
        start_q <= d_s2_q[4:0];
      end
      if (c_page) begin
        page_q <= d_s2_q[1:0];
      end
    end
  end

  // Write FIFO carrier, declared ahead of the column counter that reads its ready
  ldd_fifo_if #(.W(FIFO_W)) fifo ();

  // Column counter and read-modify-write mode
  logic [6:0] col_q, rmw_col_q;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      col_q     <= RST_COL;
      rmw_q     <= 1'b0;
      rmw_col_q <= RST_COL;
    end else if (c_rmw) begin
      rmw_q     <= 1'b1;
      rmw_col_q <= col_q;
    end else if (c_end) begin
      rmw_q <= 1'b0;
      col_q <= rmw_col_q;
    end else if (c_col && !rmw_q) begin
      col_q <= d_s2_q[6:0];
    end else if (data_wr && fifo.in_ready) begin
      col_q <= col_next(col_q);
    end else if (data_rd_end && !rmw_q) begin
      col_q <= col_next(col_q);
    end
  end

  // Initialisation period after reset pin or reset command
  localparam int IW = $clog2(INIT_CYCLES + 1);
  logic [IW-1:0] init_cnt_q;
  logic          init_q;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      init_cnt_q <= IW'(INIT_CYCLES);
      init_q     <= 1'b1;
    end else if (c_rst) begin
      init_cnt_q <= IW'(INIT_CYCLES);
      init_q     <= 1'b1;
    end else if (init_cnt_q != '0) begin
      init_cnt_q <= init_cnt_q - 1'b1;
      init_q     <= (init_cnt_q != IW'(1));
    end
  end

  // Display RAM, write FIFO and scan
  logic [7:0] ram_q [NUM_PAGES][NUM_COLS];
  logic       slot, sc_done;
  logic [6:0] sc_col;
  logic [4:0] sc_line, sc_row, sc_done_row;

  ldd_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in    (sys_clk_in),
    .resetn_in (resetn_in),
    .bus       (fifo)
  );

  ldd_scan u_scan (
    .clk_in       (sys_clk_in),
    .resetn_in    (resetn_in),
    .run_in       (!ps_q),
    .duty32_in    (duty32_q),
    .start_in     (start_q),
    .slot_out     (slot),
    .col_out      (sc_col),
    .line_out     (sc_line),
    .row_out      (sc_row),
    .done_q_out   (sc_done),
    .done_row_out (sc_done_row)
  );

  // Host writes queue with their address; refused while full
  assign fifo.in_valid  = data_wr;
  assign fifo.in_data   = {page_q, col_q, d_s2_q};
  assign fifo.out_ready = !slot;

  // Drain into RAM in non-scan cycles; out-of-range column dropped
  always_ff @(posedge sys_clk_in) begin
    if (fifo.out_valid && fifo.out_ready && fifo.out_data[14:8] <= COL_LAST) begin
      ram_q[fifo.out_data[16:15]][fifo.out_data[14:8]] <= fifo.out_data[7:0];
    end
  end

  // Read latch: each data read returns the byte fetched by the previous one
  logic [7:0] rd_latch_q;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_latch_q <= 8'h00;
    end else if (data_rd_end) begin
      rd_latch_q <= (col_q <= COL_LAST) ? ram_q[page_q][col_q] : 8'h00;
    end
  end

  // Busy and status byte
  logic busy_d;
  logic [7:0] status;
  assign busy_d = init_q || fifo.out_valid;
  always_comb begin
    status          = 8'h00;
    status[ST_BUSY] = busy_d;
    status[ST_DIR]  = dir_q;
    status[ST_OFF]  = !disp_on_q;
    status[ST_INIT] = init_q;
  end

  // Host bus drive
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      d_out    <= 8'h00;
      d_oe_out <= 1'b0;
      busy_out <= 1'b1;
    end else begin
      busy_out <= busy_d;
      d_oe_out <= !cs_s_q[1] && !rd_s_q[1];
      if (rd_start) begin
        d_out <= dcs_s_q[1] ? rd_latch_q : status;
      end
    end
  end

  // Segment accumulation; uses the scan line, never the host page
  logic [79:0] seg_acc_q;
  logic [6:0]  seg_idx;
  assign seg_idx = dir_q ? sc_col : COL_LAST - sc_col;
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seg_acc_q <= '0;
    end else if (slot) begin
      seg_acc_q[seg_idx] <= ram_q[sc_line[4:3]][sc_col][sc_line[2:0]];
    end
  end

  // Panel outputs at each finished row
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      common_out     <= '0;
      seg_out        <= '0;
      power_save_out <= 1'b0;
    end else begin
      power_save_out <= ps_q;
      if (ps_q) begin
        common_out <= '0;
        seg_out    <= '0;
      end else if (static_q) begin
        common_out <= '1;
        seg_out    <= '1;
      end else if (sc_done) begin
        common_out <= 32'h0000_0001 << sc_done_row;
        seg_out    <= disp_on_q ? seg_acc_q : '0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);

  property p_ps_entry;
    !disp_on_d && static_d |=> ##1 power_save_out;
  endproperty
  a_ps_entry: assert property (p_ps_entry) else $error("power save not entered");
  property p_ps_leave;
    c_onoff && d_s2_q[0] |=> ##1 !power_save_out;
  endproperty
  a_ps_leave: assert property (p_ps_leave) else $error("power save not left");
  property p_col_stop;
    col_q == COL_STOP && !cmd_wr |=> col_q == COL_STOP;
  endproperty
  a_col_stop: assert property (p_col_stop) else $error("column passed stop");
  property p_col_set;
    c_col && !rmw_q |=> col_q == $past(d_s2_q[6:0]);
  endproperty
  a_col_set: assert property (p_col_set) else $error("column not loaded");
  property p_rmw_read;
    rmw_q && data_rd_end && !cmd_wr |=> $stable(col_q);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("column moved on rmw read");
  property p_reset_cmd;
    c_rst |=> start_q == RST_START && page_q == RST_PAGE && init_q;
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("reset command incomplete");
  property p_status_low;
    rd_start && !dcs_s_q[1] |=> d_out[3:0] == 4'h0 && d_out[ST_DIR] == $past(dir_q);
  endproperty
  a_status_low: assert property (p_status_low) else $error("bad status byte");
  property p_static;
    static_q && !ps_q |=> common_out == '1 && seg_out == '1;
  endproperty
  a_static: assert property (p_static) else $error("static drive not forced");
  property p_busy_init;
    c_rst |=> ##1 busy_out;
  endproperty
  a_busy_init: assert property (p_busy_init) else $error("busy low during init");
  property p_dir_set;
    c_adc |=> dir_q == $past(d_s2_q[0]);
  endproperty
  a_dir_set: assert property (p_dir_set) else $error("direction not set");

  c_write:  cover property (data_wr ##[1:40] data_rd_end);
  c_psave:  cover property (power_save_out);
  c_rowend: cover property (sc_done && sc_done_row == ROWS32_LAST);
endmodule // ldd_top

/* File: src/ldd_pkg.sv */
// Package for the LCD instruction decoder: opcodes, field positions, reset values, timing.
// Assumes a single 25 MHz system clock shared by every module of the block.
package ldd_pkg;
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          INIT_TIME_NS  = 400;                    // Initialisation period
  localparam int          INIT_CYCLES   = (INIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          NUM_COLS      = 80;
  localparam int          NUM_PAGES     = 4;
  localparam logic [6:0]  COL_LAST      = 7'h4F;
  localparam logic [6:0]  COL_STOP      = 7'h50;
  localparam logic [4:0]  ROWS16_LAST   = 5'h0F;
  localparam logic [4:0]  ROWS32_LAST   = 5'h1F;
  // Command opcodes and match masks
  localparam logic [7:0]  OP_ON_OFF     = 8'hAE;
  localparam logic [7:0]  OP_ADC        = 8'hA0;
  localparam logic [7:0]  OP_STATIC     = 8'hA4;
  localparam logic [7:0]  OP_DUTY       = 8'hA8;
  localparam logic [7:0]  OP_START      = 8'hC0;
  localparam logic [7:0]  OP_PAGE       = 8'hB8;
  localparam logic [7:0]  OP_RMW        = 8'hE0;
  localparam logic [7:0]  OP_END        = 8'hEE;
  localparam logic [7:0]  OP_RESET      = 8'hE2;
  localparam logic [7:0]  MASK_BIT      = 8'hFE;
  localparam logic [7:0]  MASK_START    = 8'hE0;
  localparam logic [7:0]  MASK_PAGE     = 8'hFC;
  localparam logic [7:0]  MASK_FULL     = 8'hFF;
  localparam logic [7:0]  MASK_COL      = 8'h80;
  localparam logic [7:0]  OP_COL        = 8'h00;
  // Status byte bit positions
  localparam int          ST_BUSY       = 7;
  localparam int          ST_DIR        = 6;
  localparam int          ST_OFF        = 5;
  localparam int          ST_INIT       = 4;
  // Reset values
  localparam logic [1:0]  RST_PAGE      = 2'h3;
  localparam logic [4:0]  RST_START     = 5'h00;
  localparam logic [6:0]  RST_COL       = 7'h00;
  localparam logic        RST_DUTY32    = 1'b1;
  localparam logic        RST_DIR       = 1'b0;
  localparam int          FIFO_W        = 17;                     // {page, column, byte}

  // Full-opcode comparison under a mask
  function automatic logic op_match(input logic [7:0] b, input logic [7:0] op,
                                    input logic [7:0] mask);
    return (b & mask) == op;
  endfunction

  // Column advance that stops at the end marker
  function automatic logic [6:0] col_next(input logic [6:0] c);
    return (c < COL_STOP) ? c + 7'h01 : c;
  endfunction
endpackage

/* File: src/ldd_fifo_if.sv */
// Interface carrying the write stream into and out of the display-data FIFO.
// Assumes producer and consumer share the FIFO's clock.
`timescale 1ns/1ps
interface ldd_fifo_if #(parameter int W = 17);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

/* File: src/ldd_fifo.sv */
// Synchronous FIFO holding display-data writes until the RAM port is free.
// Assumes one clock; full and empty are exact, ready drops when full.
`timescale 1ns/1ps
module ldd_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 16
) (
  input  wire logic clk_in,      // System clock
  input  wire logic resetn_in,   // Async reset, active low
  ldd_fifo_if.fifo  bus          // Fill and drain sides
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic         full;
  logic         empty;

  // Pointer compare with wrap bit
  assign full          = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty         = (wp_q == rp_q);
  assign bus.in_ready  = !full;
  assign bus.out_valid = !empty;
  assign bus.out_data  = mem_q[rp_q[AW-1:0]];

  // Storage write
  always_ff @(posedge clk_in) begin
    if (bus.in_valid && !full) begin
      mem_q[wp_q[AW-1:0]] <= bus.in_data;
    end
  end

  // Write pointer
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wp_q <= '0;
    end else if (bus.in_valid && !full) begin
      wp_q <= wp_q + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rp_q <= '0;
    end else if (bus.out_ready && !empty) begin
      rp_q <= rp_q + 1'b1;
    end
  end
endmodule // ldd_fifo

/* File: src/ldd_scan.sv */
// Panel scan sequencer: walks columns and rows, gives the RAM line being shown.
// Assumes the caller reads one RAM byte in each slot cycle it flags.
`timescale 1ns/1ps
module ldd_scan
  import ldd_pkg::*;
(
  input  wire logic       clk_in,        // System clock
  input  wire logic       resetn_in,     // Async reset, active low
  input  wire logic       run_in,        // Scan runs (not power save)
  input  wire logic       duty32_in,     // 1: 32 rows, 0: 16 rows
  input  wire logic [4:0] start_in,      // RAM line on the first common
  output logic            slot_out,      // RAM read slot this cycle
  output logic [6:0]      col_out,       // Column being fetched
  output logic [4:0]      line_out,      // RAM line being fetched
  output logic [4:0]      row_out,       // Panel row being fetched
  output logic            done_q_out,    // Row finished (pulse)
  output logic [4:0]      done_row_out   // Row that just finished
);
  logic       phase_q;
  logic [6:0] col_q;
  logic [4:0] row_q;
  logic [4:0] last_row;

  assign last_row = duty32_in ? ROWS32_LAST : ROWS16_LAST;
  assign slot_out = phase_q && run_in;
  assign col_out  = col_q;
  assign row_out  = row_q;
  // First common shows the start line, later rows follow in order
  assign line_out = start_in + row_q;

  // Alternate read slots with drain slots
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= run_in ? !phase_q : 1'b0;
    end
  end

  // Column and row counters
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      col_q        <= RST_COL;
      row_q        <= '0;
      done_q_out   <= 1'b0;
      done_row_out <= '0;
    end else begin
      done_q_out <= 1'b0;
      if (slot_out) begin
        if (col_q == COL_LAST) begin
          col_q        <= RST_COL;
          done_q_out   <= 1'b1;
          done_row_out <= row_q;
          row_q        <= (row_q >= last_row) ? 5'h00 : row_q + 5'h01;
        end else begin
          col_q <= col_q + 7'h01;
        end
      end
    end
  end
endmodule // ldd_scan

/* File: sim/ldd_host_model.sv */
// Host bus model: an 80-style processor making one bus cycle per call.
// Assumes the device passes strobes through a two-stage synchroniser.
`timescale 1ns/1ps
module ldd_host_model (
  input  wire logic       clk_in,    // System clock
  input  wire logic [7:0] rdata_in,  // Device data out
  input  wire logic       oe_in,     // Device drive enable
  output logic            cs_n_out,  // Chip select, active low
  output logic            sel_out,   // Data/command select
  output logic            rd_n_out,  // Read strobe, active low
  output logic            wr_n_out,  // Write strobe, active low
  output logic [7:0]      d_out      // Host data bus
);
  // Idle bus at time zero
  initial begin
    cs_n_out = 1'b1;
    sel_out  = 1'b0;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    d_out    = 8'h00;
  end
  // Setup 3 clocks, strobe low 4, hold 4, then release the bus
  task automatic acc(input logic r, input logic s, input logic [7:0] w,
                     output logic [7:0] q, output logic e);
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    sel_out  <= s;
    d_out    <= w;
    repeat (3) @(posedge clk_in);
    rd_n_out <= !r;
    wr_n_out <= r;
    repeat (4) @(posedge clk_in);
    q = rdata_in;
    e = oe_in;
    rd_n_out <= 1'b1;
    wr_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    d_out    <= ~w;  // Released bus shows the inverse
  endtask
endmodule // ldd_host_model

/* File: sim/lcd_driver_instruction_decoder_bench.sv */
// Bench: host model drives the decoder, an integer model predicts results.
// Assumes one 25 MHz clock and the host model's bus timing.
`timescale 1ns/1ps
module lcd_driver_instruction_decoder_bench import ldd_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cs_n, sel, rd_n, wr_n, oe, ps, busy, oe_seen;
  logic [7:0]  d_w, d_r, q;
  logic [31:0] com, seen;
  logic [79:0] seg;
  int          miscompares = 0, checks_done = 0, cyc = 0;
  int          ram [4][80];
  int          pg = 3, col = 0, rcol = 0, lat = -1;
  bit          rmw, on, dir, stat;
  logic [7:0]  cmds [5] = '{8'hAA, 8'hA1, 8'hAF, 8'hA0, 8'hA1};

  // Clock and hang guard
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      end_of_test();
    end
  end

  ldd_host_model i_ldd_host_model (.clk_in(clk), .rdata_in(d_r), .oe_in(oe), .cs_n_out(cs_n),
    .sel_out(sel), .rd_n_out(rd_n), .wr_n_out(wr_n), .d_out(d_w));
  ldd_top #(.FIFO_DEPTH(16)) i_ldd_top (.sys_clk_in(clk), .resetn_in(rstn),
    .cs_n_in(cs_n), .data_command_select_in(sel), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .d_in(d_w), .d_out(d_r), .d_oe_out(oe), .common_out(com), .seg_out(seg),
    .power_save_out(ps), .busy_out(busy));

  task automatic chk(input string n, input logic [79:0] e, input logic [79:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // Poll busy under a bound
  task automatic idle();
    int n;
    n = 0;
    // Let the edge that launches busy for the last transfer pass first
    @(posedge clk);
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("busy_out", 0, busy);
  endtask
  // Command effects on the model
  task automatic cmd(input logic [7:0] b);
    if (!b[7]) begin
      if (!rmw) col = b[6:0];
      lat = -1;
    end
    else if (b[7:2] == 6'h2E) pg = b[1:0];
    else if (b == 8'hE0) begin
      rmw = 1;
      rcol = col;
    end
    else if (b == 8'hEE) begin
      rmw = 0;
      col = rcol;
      lat = -1;
    end
    else if (b == 8'hE2) pg = 3;
    else if (b[7:1] == 7'h57) on = b[0];
    else if (b[7:1] == 7'h50) dir = b[0];
    else if (b[7:1] == 7'h52) stat = b[0];
  endtask
  // One bus cycle, compared against the model
  task automatic op(input logic r, input logic s, input logic [7:0] b);
    i_ldd_host_model.acc(r, s, b, q, oe_seen);
    chk("d_oe_out", r, oe_seen);
    if (r && !s) chk("status", {1'b0, dir, !on, 5'h00}, q);
    else if (r) begin
      if (lat >= 0) chk("rd_data", lat, q);
      lat = (col < 80) ? ram[pg][col] : -1;
      if (!rmw && col < 80) col++;
    end
    else if (s) begin
      if (col < 80) ram[pg][col] = b;
      if (col < 80) col++;
      lat = -1;
    end
    else begin
      cmd(b);
      repeat (4) @(posedge clk);
      chk("power_save_out", !on && stat, ps);
    end
    idle();
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    void'($urandom(32'h0227));
    foreach (ram[i, j]) ram[i][j] = -1;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chk("busy_out", 1, busy);
    idle();
    op(1, 0, 0);
    foreach (cmds[i]) begin
      op(0, 0, cmds[i]);
      op(1, 0, 0);
    end
    for (int p = 0; p < 4; p++) begin
      op(0, 0, 8'hB8 | 8'(p));
      op(0, 0, 8'h4E);
      repeat (3) op(0, 1, 8'($urandom));
      op(0, 0, 8'h00);
      op(0, 1, 8'($urandom));
    end
    for (int p = 0; p < 4; p++) begin
      op(0, 0, 8'hB8 | 8'(p));
      op(0, 0, 8'h4E);
      repeat (4) op(1, 1, 0);
      op(0, 0, 8'h00);
      repeat (2) op(1, 1, 0);
    end
    op(0, 0, 8'hE2);
    op(0, 0, 8'h10);
    op(0, 1, 8'($urandom));
    op(0, 0, 8'h10);
    repeat (2) op(1, 1, 0);
    op(0, 0, 8'h20);
    op(0, 0, 8'hE0);
    repeat (3) op(1, 1, 0);
    op(0, 1, 8'($urandom));
    op(0, 0, 8'h25);
    op(0, 1, 8'($urandom));
    op(0, 0, 8'hEE);
    repeat (3) op(1, 1, 0);
    op(0, 0, 8'hA5);
    repeat (400) @(posedge clk);
    chk("common_out", 32'hFFFFFFFF, com);
    chk("seg_out", {80{1'b1}}, seg);
    op(0, 0, 8'hAE);
    op(1, 0, 0);
    op(0, 0, 8'hAF);
    op(0, 0, 8'hA4);
    op(0, 0, 8'hAE);
    repeat (200) @(posedge clk);
    chk("seg_out", 0, seg);
    op(0, 0, 8'hA5);
    op(0, 0, 8'hA4);
    op(0, 0, 8'hAF);
    // Commons seen over a frame for each duty
    for (int d = 0; d < 2; d++) begin
      op(0, 0, 8'hA8 | 8'(d));
      repeat (5400) @(posedge clk);
      seen = 32'h0;
      repeat (5200) begin
        @(posedge clk);
        seen |= com;
      end
      chk("commons", d ? 32'hFFFFFFFF : 32'h0000FFFF, seen);
    end
    end_of_test();
  end
endmodule // lcd_driver_instruction_decoder_bench
